// ===== verilog/dpsem_pkg.sv
// Constants and types for the semaphore port controller
package dpsem_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  // Strobe widths and recovery, in ns
  localparam int unsigned STROBE_NS       = 80;
  localparam int unsigned RECOVER_NS      = 40;
  localparam int unsigned STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC     = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 4;
  localparam int unsigned FLAG_COUNT      = 8;
  localparam int unsigned IDX_W           = 3;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 8;
  localparam logic [CNT_W-1:0] CNT_STROBE  = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] CNT_RECOVER = CNT_W'(RECOVER_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;
  localparam logic [IDX_W-1:0] IDX_ZERO    = 3'h0;
  localparam logic [IDX_W-1:0] IDX_LAST    = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE   = 8'h01;

  // Host commands
  localparam logic [1:0] CMD_ACQUIRE = 2'h0;
  localparam logic [1:0] CMD_RELEASE = 2'h1;
  localparam logic [1:0] CMD_POLL    = 2'h2;
  localparam logic [1:0] CMD_INIT    = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_WR    = 6'b000010,
    ST_WGAP  = 6'b000100,
    ST_RD    = 6'b001000,
    ST_RGAP  = 6'b010000,
    ST_DONE  = 6'b100000
  } dpsem_state_t;
endpackage

// ===== verilog/dpsem_host.sv
// Host-side controller driving one port's semaphore space
//
// Summary of operation
// - Write zero requests, write one releases
// - Drop select between polling reads
// - Acquire by write zero then read
// - After failure reread or write one
// - Write one to every flag at start
`timescale 1ns/1ps
module dpsem_host
  import dpsem_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Command port
  input  wire logic              cmd_valid_i,
  input  wire logic [1:0]        cmd_op_i,
  input  wire logic [IDX_W-1:0]  cmd_flag_i,
  output logic                   cmd_ready_o,
  output logic                   done_o,
  output logic                   granted_o,
  output logic [DATA_W-1:0]      rd_data_o,
  // Device port pins
  output logic                   chip_sel_n_o,
  output logic                   flag_space_select_n_o,
  output logic                   wr_n_o,
  output logic                   out_en_n_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_n_o,
  input  wire logic [DATA_W-1:0] data_i
);

  typedef struct packed {
    dpsem_state_t       st;
    logic [CNT_W-1:0]   cnt;
    logic [1:0]         op;
    logic [IDX_W-1:0]   idx;
    logic               rdy;
    logic               done;
    logic               granted;
    logic [DATA_W-1:0]  rdat;
    logic               sem_n;
    logic               wr_n;
    logic               oe_n;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  dout;
    logic               doe_n;
    logic               cs_n;
  } dpsem_regs_t;

  dpsem_regs_t r;
  dpsem_regs_t next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      ST_IDLE: begin
        next_r.rdy = 1'b1;
        if (cmd_valid_i && r.rdy) begin
          next_r.rdy  = 1'b0;
          next_r.op   = cmd_op_i;
          next_r.idx  = (cmd_op_i == CMD_INIT) ? IDX_ZERO : cmd_flag_i;
          next_r.cnt  = CNT_STROBE;
          next_r.sem_n = 1'b0;
          next_r.addr = {{(ADDR_W-IDX_W){1'b0}},
                         (cmd_op_i == CMD_INIT) ? IDX_ZERO : cmd_flag_i};
          if (cmd_op_i == CMD_POLL) begin
            next_r.oe_n = 1'b0;
            next_r.st   = ST_RD;
          end else begin
            // Acquire writes zero; release and init write one
            next_r.dout  = (cmd_op_i == CMD_ACQUIRE) ? DATA_ZERO : DATA_ONE;
            next_r.doe_n = 1'b0;
            next_r.wr_n  = 1'b0;
            next_r.st    = ST_WR;
          end
        end
      end
      ST_WR: begin
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt == CNT_ONE) begin
          next_r.wr_n  = 1'b1;
          next_r.sem_n = 1'b1;
          next_r.doe_n = 1'b1;
          next_r.cnt   = CNT_RECOVER;
          next_r.st    = ST_WGAP;
        end
      end
      ST_WGAP: begin
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt == CNT_ONE) begin
          next_r.cnt = CNT_STROBE;
          next_r.sem_n = 1'b0;
          if (r.op == CMD_ACQUIRE) begin
            // Write first, then read back
            next_r.oe_n = 1'b0;
            next_r.st   = ST_RD;
          end else if (r.op == CMD_INIT && r.idx != IDX_LAST) begin
            next_r.idx   = r.idx + 3'h1;
            next_r.addr  = {{(ADDR_W-IDX_W){1'b0}}, r.idx + 3'h1};
            next_r.doe_n = 1'b0;
            next_r.wr_n  = 1'b0;
            next_r.st    = ST_WR;
          end else begin
            next_r.sem_n = 1'b1;
            next_r.st    = ST_DONE;
          end
        end
      end
      ST_RD: begin
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt == CNT_ONE) begin
          // Sample at strobe end; drop both strobes so next poll relatches
          next_r.rdat    = data_i;
          next_r.granted = ~data_i[0];
          next_r.oe_n    = 1'b1;
          next_r.sem_n   = 1'b1;
          next_r.cnt     = CNT_RECOVER;
          next_r.st      = ST_RGAP;
        end
      end
      ST_RGAP: begin
        next_r.cnt = r.cnt - CNT_ONE;
        if (r.cnt == CNT_ONE) begin
          next_r.st = ST_DONE;
        end
      end
      ST_DONE: begin
        // A failed acquire leaves the request latched; caller polls or releases
        if (r.op == CMD_RELEASE || r.op == CMD_INIT) begin
          next_r.granted = 1'b0;
        end
        next_r.done = 1'b1;
        next_r.rdy  = 1'b1;
        next_r.st   = ST_IDLE;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      // Pins park in standby so the far device sees no stray access
      r         <= '0;
      r.st      <= ST_IDLE;
      r.cs_n    <= 1'b1;
      r.sem_n   <= 1'b1;
      r.wr_n    <= 1'b1;
      r.oe_n    <= 1'b1;
      r.doe_n   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready_o           = r.rdy;
  assign done_o                = r.done;
  assign granted_o             = r.granted;
  assign rd_data_o             = r.rdat;
  // Array never touched: semaphore space only
  assign chip_sel_n_o          = r.cs_n;
  assign flag_space_select_n_o = r.sem_n;
  assign wr_n_o                = r.wr_n;
  assign out_en_n_o            = r.oe_n;
  assign addr_o                = r.addr;
  assign data_o                = r.dout;
  assign data_oe_n_o           = r.doe_n;

  // Checks on the pins this controller drives
  a_write_read_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !r.wr_n |-> r.oe_n) else $error("write and read strobes overlap");
  a_poll_release_gap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $fell(r.oe_n) |-> $past(r.sem_n)) else $error("read without select gap");
  a_write_data_bit: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !r.wr_n |-> r.dout[DATA_W-1:1] == '0) else $error("upper data bits set");
  a_flag_addr_range: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !r.sem_n |-> r.addr[ADDR_W-1:IDX_W] == '0) else $error("high address set");
  a_strobe_with_select: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!r.wr_n || !r.oe_n) |-> !r.sem_n) else $error("strobe without select");
  a_grant_from_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (r.st == ST_RD && r.cnt == CNT_ONE) |=> granted_o == ~$past(data_i[0]))
    else $error("grant not from readback");
  a_done_pulse_one: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    done_o |=> !done_o) else $error("done longer than a cycle");
  a_standby_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    r.st == ST_IDLE |-> r.sem_n && r.wr_n && r.oe_n) else $error("idle not standby");
  a_acquire_zero_data: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!r.wr_n && r.op == CMD_ACQUIRE) |-> r.dout == DATA_ZERO) else $error("acquire not zero");
  a_release_one_data: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!r.wr_n && r.op != CMD_ACQUIRE) |-> r.dout == DATA_ONE) else $error("release not one");
  a_write_drives_bus: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !r.wr_n |-> !r.doe_n) else $error("write with data bus released");
  a_write_gap_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    r.st == ST_WGAP |-> r.wr_n && r.doe_n) else $error("write not ended before readback");
  a_readback_follows: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (r.st == ST_WGAP && r.cnt == CNT_ONE && r.op == CMD_ACQUIRE) |=> !r.oe_n && !r.sem_n)
    else $error("acquire write not followed by read");
  a_poll_gap_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    r.st == ST_RGAP |-> r.oe_n && r.sem_n) else $error("strobes held between reads");
  a_release_drops_grant: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (r.st == ST_DONE && (r.op == CMD_RELEASE || r.op == CMD_INIT)) |=> !granted_o)
    else $error("grant kept after release");
endmodule

// ===== tb/dpsem_dev_model.sv
// Behavioural semaphore device: host port pins plus a scripted far port
`timescale 1ns/1ps
module dpsem_dev_model (
  input  wire logic        clk_i,
  input  wire logic        sem_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        doe_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  din_i,
  output logic [7:0]       dout_o
);
  // Owner 0 free, 1 host, 2 far; power-up garbage on purpose
  logic [1:0] own [8];
  logic [1:0] req [8];
  logic [7:0] q = 8'h00;
  logic       act_q = 1'b0;
  initial for (int i = 0; i < 8; i++) begin
    own[i] = 2'd2;
    req[i] = 2'b01;
  end
  task automatic wr(input int s, input logic [2:0] i, input logic v);
    if (!v) begin
      if (own[i] == 2'd0) own[i] = 2'(s);
      else if (own[i] != 2'(s)) req[i][s-1] = 1'b1;
    end else begin
      req[i][s-1] = 1'b0;
      if (own[i] == 2'(s)) begin
        own[i] = req[i][2-s] ? 2'(3-s) : 2'd0;
        req[i][2-s] = 1'b0;
      end
    end
  endtask
  // Host writes on clock edges, far writes only while the host is idle: no exact ties
  always @(posedge clk_i) begin
    // Undriven data bus floats high, so a missing drive loses the acquire
    if (!sem_n_i && !wr_n_i) wr(1, addr_i[2:0], din_i[0] | doe_n_i);
    if (!sem_n_i && !oe_n_i && !act_q) q <= {8{own[addr_i[2:0]] != 2'd1}};
    act_q <= !sem_n_i && !oe_n_i;
  end
  // Idle bus shows the inverse so a stale match cannot pass
  assign dout_o = (!sem_n_i && !oe_n_i) ? q : ~q;
endmodule

// ===== tb/dpsem_host_test.sv
// Self-checking bench for the semaphore host controller
`timescale 1ns/1ps
module dpsem_host_test;
  import dpsem_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              cmd_valid_i = 1'b0;
  logic [1:0]        cmd_op_i = CMD_INIT;
  logic [IDX_W-1:0]  cmd_flag_i = IDX_ZERO;
  logic              rdy, done, grant, cs_n, sem_n, wr_n, oe_n, doe_n;
  logic [DATA_W-1:0] rd_data, dout, din;
  logic [ADDR_W-1:0] addr;
  int                errors = 0;
  int                total_checks = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  dpsem_host dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_flag_i(cmd_flag_i), .cmd_ready_o(rdy), .done_o(done),
    .granted_o(grant), .rd_data_o(rd_data), .chip_sel_n_o(cs_n),
    .flag_space_select_n_o(sem_n), .wr_n_o(wr_n), .out_en_n_o(oe_n), .addr_o(addr),
    .data_o(dout), .data_oe_n_o(doe_n), .data_i(din));
  dpsem_dev_model dev (.clk_i(ref_clk_i), .sem_n_i(sem_n), .wr_n_i(wr_n), .oe_n_i(oe_n),
    .doe_n_i(doe_n), .addr_i(addr), .din_i(dout), .dout_o(din));
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic [2:0] f);
    int n;
    n = 0;
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_flag_i <= f;
    do @(posedge ref_clk_i); while (rdy !== 1'b1);
    cmd_valid_i <= 1'b0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (done !== 1'b1 && n < 400);
    check({7'h00, done}, 8'h01, "done");
  endtask
  task automatic t_init();
    run(CMD_INIT, IDX_ZERO);
    for (int i = 0; i < 8; i++) dev.wr(2, 3'(i), 1'b1);
    check({7'h00, grant}, 8'h00, "granted after init");
    for (int i = 0; i < 8; i++) check({6'h00, dev.own[i]}, 8'h00, "free");
  endtask
  task automatic t_hand_over();
    run(CMD_ACQUIRE, 3'h2);
    check(rd_data, 8'h00, "won readback");
    check({7'h00, grant}, 8'h01, "granted");
    dev.wr(2, 3'h2, 1'b0);
    run(CMD_POLL, 3'h2);
    check(rd_data, 8'h00, "still held");
    run(CMD_RELEASE, 3'h2);
    check({6'h00, dev.own[2]}, 8'h02, "passed to far");
    run(CMD_POLL, 3'h2);
    check(rd_data, 8'hFF, "far holds");
    check({7'h00, grant}, 8'h00, "not granted");
  endtask
  task automatic t_lost_request();
    dev.wr(2, 3'h5, 1'b0);
    run(CMD_ACQUIRE, 3'h5);
    check(rd_data, 8'hFF, "lost readback");
    check({7'h00, grant}, 8'h00, "lost grant");
    dev.wr(2, 3'h5, 1'b1);
    run(CMD_POLL, 3'h5);
    check(rd_data, 8'h00, "pending wins");
    check({7'h00, grant}, 8'h01, "late grant");
    run(CMD_RELEASE, 3'h5);
    check({6'h00, dev.own[5]}, 8'h00, "freed");
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    t_init();
    t_hand_over();
    t_lost_request();
    check({7'h00, cs_n}, 8'h01, "array unselected");
    report_and_stop();
  end
  // About 86 cycles expected
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    errors++;
    report_and_stop();
  end
endmodule
